// >>> design/srs_pkg.sv
/*
 * package of the service request status logic: status byte layout,
 * reset values, mask defaults and state codes.
 * assumes a single 25 MHz clock and a synchronous active-high reset.
 */
package srs_pkg;

    // ****************************************************************
    // status byte layout
    // ****************************************************************
    localparam int STB_W          = 8;
    localparam int COND_W         = 6;
    localparam int BIT_UNKNOWN    = 0;   // statement not recognised
    localparam int BIT_BADVAL     = 1;   // wrong value programmed
    localparam int BIT_AUTOCORR   = 2;   // autocorrection done
    localparam int BIT_USERKEY    = 3;   // user key request
    localparam int BIT_STOPPED    = 4;   // stop routine executed
    localparam int BIT_FASTCLK    = 5;   // fast clock detected
    localparam int BIT_SUMMARY    = 6;   // request service summary
    localparam int BIT_SELFTEST   = 7;   // power-on test failed

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [COND_W-1:0] MASK_DEFAULT   = 6'h3f;
    localparam logic [STB_W-1:0]  STB_RESET      = 8'h00;
    localparam logic [COND_W-1:0] COND_NONE      = 6'h00;

    // ****************************************************************
    // acquisition
    // ****************************************************************
    localparam int ACQ_ADDR_W = 12;
    localparam logic [ACQ_ADDR_W-1:0] ACQ_LAST = 12'hfff;

    typedef enum logic [2:0] {
        ACQ_IDLE = 3'b001,
        ACQ_RUN  = 3'b010,
        ACQ_STOP = 3'b100
    } srs_acq_t;

    // true when any of the six condition bits is set
    function automatic logic srs_any(input logic [COND_W-1:0] c);
        return |c;
    endfunction

endpackage

// >>> design/srs_cond_if.sv
/*
 * interface carrying the condition events from the front-end to the
 * two-level status registers.
 * assumes one clock domain shared by both ends.
 */
interface srs_cond_if;
    import srs_pkg::*;

    logic [COND_W-1:0] events;     // one-cycle condition pulses, masked
    logic              selfFail;   // self test failed level

    modport src (output events, output selfFail);
    modport dst (input events, input selfFail);
endinterface

// >>> design/srs_event_gate.sv
/*
 * front-end: holds the enable mask, keeps the first-error-per-line
 * filter, and runs the acquisition sequencer that fires the stop event.
 * assumes synchronous inputs, one-cycle pulses on the event ports.
 */
module srs_event_gate
    import srs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              maskWrite,
    input  wire logic [COND_W-1:0] maskValue,
    input  wire logic              addrChange,
    input  wire logic              lineStart,
    input  wire logic              errUnknown,
    input  wire logic              errBadValue,
    input  wire logic              autoCorrect,
    input  wire logic              userKey,
    input  wire logic              fastClock,
    input  wire logic              stopRoutine,
    input  wire logic              acqStart,
    input  wire logic              sampleStrobe,
    input  wire logic              selfTestFail,
    input  wire logic              localAck,
    output logic [COND_W-1:0]      mask,
    output logic                   remoteBlocked,
    output logic                   acqRunning,
    srs_cond_if.src                cond
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [COND_W-1:0] mask_q;
    logic              lineErr_q;
    logic              blocked_q;
    logic              acked_q;
    logic [ACQ_ADDR_W-1:0] addr_q;
    srs_acq_t          acq_q;
    srs_acq_t          acq_d;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire               anyErr    = errUnknown | errBadValue;
    wire               firstErr  = anyErr & ~lineErr_q & ~lineStart;
    wire               memFull   = (acq_q == ACQ_RUN) && sampleStrobe && (addr_q == ACQ_LAST);
    wire               stopEvent = stopRoutine | (acq_q == ACQ_STOP);
    wire               errKeep   = lineStart ? anyErr : firstErr;
    wire [COND_W-1:0]  rawEvents = {fastClock, stopEvent, userKey, autoCorrect,
                                    errBadValue & errKeep, errUnknown & errKeep};

    assign cond.events   = rawEvents & mask_q;
    assign cond.selfFail = selfTestFail;
    assign mask          = mask_q;
    assign remoteBlocked = blocked_q;
    assign acqRunning    = (acq_q == ACQ_RUN);

    // acquisition sequencer next state
    always_comb begin
        case (acq_q)
            ACQ_IDLE: acq_d = acqStart ? ACQ_RUN : ACQ_IDLE;
            ACQ_RUN:  acq_d = memFull ? ACQ_STOP : ACQ_RUN;
            ACQ_STOP: acq_d = ACQ_IDLE;
            default:  acq_d = ACQ_IDLE;
        endcase
    end

    // mask: forced to all enabled on reset and on address change
    always_ff @(posedge clock) begin
        if (sys_rst || addrChange) begin
            mask_q <= MASK_DEFAULT;
        end else if (maskWrite) begin
            mask_q <= maskValue;
        end
    end

    // one error flagged per programming line
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lineErr_q <= 1'b0;
        end else if (lineStart) begin
            lineErr_q <= anyErr;
        end else if (anyErr) begin
            lineErr_q <= 1'b1;
        end
    end

    // remote lockout after a failed self test until local acknowledge;
    // the fail input is a level, so an acknowledged lockout is remembered
    // until the next reset or it would come straight back
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            blocked_q <= 1'b0;
            acked_q   <= 1'b0;
        end else if (localAck) begin
            blocked_q <= 1'b0;
            acked_q   <= acked_q | blocked_q;
        end else if (selfTestFail && !acked_q) begin
            blocked_q <= 1'b1;
        end
    end

    // sequencer state and capture address
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acq_q  <= ACQ_IDLE;
            addr_q <= '0;
        end else begin
            acq_q <= acq_d;
            if (acq_q == ACQ_IDLE && acqStart) begin
                addr_q <= '0;
            end else if (acq_q == ACQ_RUN && sampleStrobe) begin
                addr_q <= addr_q + 1'b1;
            end
        end
    end

endmodule

// >>> design/srs_status_regs.sv
/*
 * two-level status store: service request register and accumulation
 * register, with the status byte and the request flag behind the bus request line.
 * assumes conditions arrive already masked as one-cycle pulses.
 */
module srs_status_regs
    import srs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              pollStrobe,
    srs_cond_if.dst                cond,
    output logic [STB_W-1:0]       reqReg,
    output logic [COND_W-1:0]      accReg,
    output logic                   srqActive
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [COND_W-1:0] req_q;
    logic [COND_W-1:0] req_d;
    logic [COND_W-1:0] acc_q;
    logic [COND_W-1:0] acc_d;
    logic              fail_q;

    // ****************************************************************
    // next-state decode
    // ****************************************************************
    wire reqEmpty  = ~srs_any(req_q);
    wire toReq     = reqEmpty & ~pollStrobe;
    wire accEmpty  = ~srs_any(acc_q);

    // a poll returns req, then req takes acc and acc empties; events in
    // the poll cycle go to req when acc is empty, else to acc, so none
    // is lost and none sits in acc without a request line behind it
    always_comb begin
        if (pollStrobe) begin
            req_d = accEmpty ? cond.events : acc_q;
            acc_d = accEmpty ? COND_NONE : cond.events;
        end else if (toReq) begin
            req_d = cond.events;
            acc_d = acc_q;
        end else begin
            req_d = req_q;
            acc_d = acc_q | cond.events;
        end
    end

    // status byte: summary follows any lower bit, top bit never requests
    assign reqReg    = {fail_q, srs_any(req_q), req_q};
    assign accReg    = acc_q;
    assign srqActive = srs_any(req_q);

    // state update
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            req_q  <= COND_NONE;
            acc_q  <= COND_NONE;
            fail_q <= 1'b0;
        end else begin
            req_q  <= req_d;
            acc_q  <= acc_d;
            fail_q <= cond.selfFail;
        end
    end

endmodule

// >>> design/srs_service_request.sv
/*
 * top of the service request status logic: wires the event front-end
 * to the two-level status store, drives the bus request line and
 * returns the status byte on a serial poll.
 * assumes a 25 MHz clock, synchronous inputs, one-cycle event pulses,
 * and a poll strobe of one cycle per serial poll addressed to us.
 */
// Operation
// - first event with empty request register sets its bit and summary there
// - serial poll returns request register and clears it
// - later events before the poll are ored into the accumulator
// - each poll moves a non-empty accumulator into request register, refilling accumulator with poll-cycle events
// - repeated events of one type collapse into one bit
// - self test failure sets top bit, no request, locks remote until acknowledge
// - two polls with no new events empty the request register except self test failure
// - stop routine sets the stop-executed bit, weight 16
// - summary bit set whenever any lower six bits is set
// - six-bit enable mask, one enables the condition
// - mask forced to 63 at power-on and on address switch change
// - masked user key is hidden and disabled in remote mode
// - device-made parameter change sets the autocorrection bit
// - request line held until polled, poll answered with status byte
// - only the first erroneous command of a programming line is flagged
// - acquisition runs until memory full, then stops and requests
// - bit meanings low to high as listed in the package
// - eight-bit status byte, bits set independently and together
// - request raised for stop, fast clock, bad command, absent hardware, user key
module srs_service_request
    import srs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              pollStrobe,
    input  wire logic              maskWrite,
    input  wire logic [COND_W-1:0] maskValue,
    input  wire logic              addrChange,
    input  wire logic              remoteMode,
    input  wire logic              lineStart,
    input  wire logic              errUnknown,
    input  wire logic              errBadValue,
    input  wire logic              errNoHardware,
    input  wire logic              paramForced,
    input  wire logic              userKeyPress,
    input  wire logic              fastClock,
    input  wire logic              stopRoutine,
    input  wire logic              acqStart,
    input  wire logic              sampleStrobe,
    input  wire logic              selfTestFail,
    input  wire logic              localAck,
    output logic [STB_W-1:0]       statusByte,
    output logic                   statusValid,
    output logic                   srqOut,
    output logic                   userKeyShown,
    output logic                   remoteBlocked,
    output logic                   acqRunning,
    output logic [COND_W-1:0]      mask
);

    // ****************************************************************
    // internal wiring
    // ****************************************************************
    srs_cond_if        condBus ();
    logic [STB_W-1:0]  reqReg;
    logic              srqActive;
    logic [STB_W-1:0]  stb_q;
    logic              valid_q;
    logic              srq_q;

    // user key only counts when enabled or when operated locally
    wire keyEnabled = mask[BIT_USERKEY] | ~remoteMode;
    wire userKeyEvt = userKeyPress & keyEnabled;
    wire badCommand = errUnknown | errNoHardware;

    assign userKeyShown = keyEnabled;

    // ****************************************************************
    // event front-end
    // ****************************************************************
    srs_event_gate u_gate (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .maskWrite     (maskWrite),
        .maskValue     (maskValue),
        .addrChange    (addrChange),
        .lineStart     (lineStart),
        .errUnknown    (badCommand),
        .errBadValue   (errBadValue),
        .autoCorrect   (paramForced),
        .userKey       (userKeyEvt),
        .fastClock     (fastClock),
        .stopRoutine   (stopRoutine),
        .acqStart      (acqStart),
        .sampleStrobe  (sampleStrobe),
        .selfTestFail  (selfTestFail),
        .localAck      (localAck),
        .mask          (mask),
        .remoteBlocked (remoteBlocked),
        .acqRunning    (acqRunning),
        .cond          (condBus.src)
    );

    // ****************************************************************
    // two-level status store
    // ****************************************************************
    srs_status_regs u_regs (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .pollStrobe (pollStrobe),
        .cond       (condBus.dst),
        .reqReg     (reqReg),
        .accReg     (),
        .srqActive  (srqActive)
    );

    // ****************************************************************
    // poll answer and request line
    // ****************************************************************
    // status byte latched at the poll, request line registered
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stb_q   <= STB_RESET;
            valid_q <= 1'b0;
            srq_q   <= 1'b0;
        end else begin
            valid_q <= pollStrobe;
            srq_q   <= srqActive & ~pollStrobe;
            if (pollStrobe) begin
                stb_q <= reqReg;
            end
        end
    end

    assign statusByte  = stb_q;
    assign statusValid = valid_q;
    assign srqOut      = srq_q;

endmodule

// >>> verif/srs_service_request_asserts.sv
/*
 * concurrent checks of the service request status logic at its top ports.
 * assumes one 25 MHz clock and the synchronous active-high reset sys_rst.
 */
module srs_service_request_asserts
    import srs_pkg::*;
(
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              pollStrobe,
    input wire logic              maskWrite,
    input wire logic [COND_W-1:0] maskValue,
    input wire logic              addrChange,
    input wire logic              remoteMode,
    input wire logic              stopRoutine,
    input wire logic [STB_W-1:0]  statusByte,
    input wire logic              statusValid,
    input wire logic              srqOut,
    input wire logic              userKeyShown,
    input wire logic [COND_W-1:0] mask
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // poll, request line and mask relations
    // ****************************************************************
    a_srq_after_stop: assert property (stopRoutine && mask[4] && !pollStrobe
        ##1 !pollStrobe |=> srqOut) else $error("request line late after stop");
    a_srq_held_up: assert property (srqOut && !pollStrobe |=> srqOut)
        else $error("request line dropped without a poll");
    a_srq_poll_drop: assert property (pollStrobe |=> !srqOut)
        else $error("request line still up after poll");
    a_poll_answer: assert property (pollStrobe |=> statusValid)
        else $error("no status byte after poll");
    a_answer_cause: assert property (statusValid |-> $past(pollStrobe))
        else $error("status byte without poll");
    a_summary_bit: assert property (statusValid |-> statusByte[6] == |statusByte[5:0])
        else $error("summary bit wrong");
    a_mask_load: assert property (maskWrite && !addrChange |=> mask == $past(maskValue))
        else $error("mask not loaded");
    a_mask_force: assert property (addrChange && !maskWrite |=> mask == 6'h3f)
        else $error("mask not forced to default");
    a_key_hidden: assert property (remoteMode && !mask[3] |-> !userKeyShown)
        else $error("user key shown while masked in remote");

    c_stop_polled: cover property (statusValid && statusByte[4]);
    c_self_fail: cover property (statusValid && statusByte[7]);
    c_key_hidden: cover property (remoteMode && !userKeyShown);
endmodule

bind srs_service_request srs_service_request_asserts srs_service_request_asserts_i (
    .clock(clock), .sys_rst(sys_rst), .pollStrobe(pollStrobe), .maskWrite(maskWrite),
    .maskValue(maskValue), .addrChange(addrChange), .remoteMode(remoteMode),
    .stopRoutine(stopRoutine), .statusByte(statusByte), .statusValid(statusValid),
    .srqOut(srqOut), .userKeyShown(userKeyShown), .mask(mask));

// >>> verif/srs_poll_ctrl.sv
/*
 * bus controller model that serial-polls the status logic.
 * assumes polls are one-cycle strobes launched at the falling edge.
 */
module srs_poll_ctrl
    import srs_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             srqOut,
    input  wire logic [STB_W-1:0] statusByte,
    input  wire logic             statusValid,
    output logic                  pollStrobe,
    output logic                  requester
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pollStrobe = 1'b0;
        requester = 1'b0;
    end

    // one serial poll: strobe one cycle, take the byte the cycle after
    task automatic poll(output logic [STB_W-1:0] b, output logic v);
        @(negedge clock);
        pollStrobe = 1'b1;
        @(negedge clock);
        pollStrobe = 1'b0;
        b = statusByte;
        v = statusValid;
        requester = statusByte[6];
    endtask
endmodule

// >>> verif/test_srs_service_request.sv
/*
 * self-checking bench of the service request status logic.
 * assumes the design package and the poll controller model.
 */
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_srs_service_request
    import srs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock, sysRst, maskWrite, addrChange, remoteMode, lineStart;
    logic       acqStart, sampleStrobe, selfTestFail, localAck;
    logic [5:0] maskValue;
    logic [6:0] ev;
    logic       pollStrobe, statusValid, srqOut, userKeyShown, remoteBlocked;
    logic       acqRunning, requester;
    logic [7:0] statusByte;
    logic [5:0] mask;
    int         bad_count = 0;
    int         total_checks = 0;

    srs_service_request srs_service_request_i (.clock(clock), .sys_rst(sysRst),
        .pollStrobe(pollStrobe), .maskWrite(maskWrite), .maskValue(maskValue),
        .addrChange(addrChange), .remoteMode(remoteMode), .lineStart(lineStart),
        .errUnknown(ev[0]), .errBadValue(ev[1]), .errNoHardware(ev[6]),
        .paramForced(ev[2]), .userKeyPress(ev[3]), .fastClock(ev[5]),
        .stopRoutine(ev[4]), .acqStart(acqStart), .sampleStrobe(sampleStrobe),
        .selfTestFail(selfTestFail), .localAck(localAck), .statusByte(statusByte),
        .statusValid(statusValid), .srqOut(srqOut), .userKeyShown(userKeyShown),
        .remoteBlocked(remoteBlocked), .acqRunning(acqRunning), .mask(mask));
    srs_poll_ctrl srs_poll_ctrl_i (.clock(clock), .srqOut(srqOut),
        .statusByte(statusByte), .statusValid(statusValid),
        .pollStrobe(pollStrobe), .requester(requester));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // shared drivers
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic fire(input logic [6:0] v, input logic ls);
        @(negedge clock);
        ev = v;
        lineStart = ls;
        @(negedge clock);
        ev = '0;
        lineStart = 1'b0;
    endtask
    task automatic set_mask(input logic [5:0] v, input logic viaAddr);
        @(negedge clock);
        maskValue = v;
        maskWrite = !viaAddr;
        addrChange = viaAddr;
        @(negedge clock);
        maskWrite = 1'b0;
        addrChange = 1'b0;
    endtask
    task automatic expect_poll(input logic [7:0] exp);
        logic [7:0] b;
        logic       v;
        srs_poll_ctrl_i.poll(b, v);
        `CHK(v, 1'b1)
        `CHK(b, exp)
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_each_bit();
        for (int i = 0; i < 7; i++) begin
            fire(7'h01 << i, 1'b1);
            step(2);
            `CHK(srqOut, 1'b1)
            expect_poll(8'h40 | (8'h01 << ((i == 6) ? 0 : i)));
        end
        `CHK(requester, 1'b1)
    endtask
    task automatic t_two_level();
        fire(7'h20, 1'b1);
        step(3);
        fire(7'h20, 1'b0);
        fire(7'h20, 1'b0);
        fire(7'h02, 1'b1);
        expect_poll(8'h60);
        expect_poll(8'h62);
        expect_poll(8'h00);
        `CHK(srqOut, 1'b0)
    endtask
    task automatic t_mask();
        set_mask(6'h10, 1'b0);
        `CHK(mask, 6'h10)
        fire(7'h11, 1'b1);
        step(2);
        expect_poll(8'h50);
        `CHK(requester, 1'b1)
        set_mask(6'h00, 1'b1);
        `CHK(mask, 6'h3f)
    endtask
    task automatic t_key_hidden();
        set_mask(6'h37, 1'b0);
        remoteMode = 1'b1;
        step(1);
        `CHK(userKeyShown, 1'b0)
        fire(7'h08, 1'b0);
        step(3);
        `CHK(srqOut, 1'b0)
        expect_poll(8'h00);
        remoteMode = 1'b0;
        set_mask(6'h00, 1'b1);
        `CHK(userKeyShown, 1'b1)
    endtask
    task automatic t_line_filter();
        fire(7'h01, 1'b1);
        fire(7'h02, 1'b0);
        step(2);
        expect_poll(8'h41);
        expect_poll(8'h00);
        // an event in the poll cycle must still raise the request line
        fork
            fire(7'h20, 1'b0);
            expect_poll(8'h00);
        join
        step(2);
        `CHK(srqOut, 1'b1)
        expect_poll(8'h60);
    endtask
    task automatic t_self_test();
        @(negedge clock);
        selfTestFail = 1'b1;
        step(3);
        `CHK(remoteBlocked, 1'b1)
        `CHK(srqOut, 1'b0)
        expect_poll(8'h80);
        expect_poll(8'h80);
        @(negedge clock);
        localAck = 1'b1;
        @(negedge clock);
        localAck = 1'b0;
        step(1);
        `CHK(remoteBlocked, 1'b0)
        selfTestFail = 1'b0;
        step(2);
        expect_poll(8'h00);
    endtask
    task automatic t_acquire();
        @(negedge clock);
        acqStart = 1'b1;
        @(negedge clock);
        acqStart = 1'b0;
        `CHK(acqRunning, 1'b1)
        sampleStrobe = 1'b1;
        step(4095);
        sampleStrobe = 1'b0;
        `CHK(acqRunning, 1'b1)
        `CHK(srqOut, 1'b0)
        @(negedge clock);
        sampleStrobe = 1'b1;
        @(negedge clock);
        sampleStrobe = 1'b0;
        step(4);
        `CHK(acqRunning, 1'b0)
        `CHK(srqOut, 1'b1)
        expect_poll(8'h50);
    endtask

    // main sequence: reset for twelve cycles, then every scenario
    initial begin
        {sysRst, maskWrite, addrChange, remoteMode, lineStart} = 5'b10000;
        {acqStart, sampleStrobe, selfTestFail, localAck} = 4'h0;
        maskValue = 6'h00;
        ev = 7'h00;
        step(12);
        sysRst = 1'b0;
        `CHK(mask, 6'h3f)
        `CHK(srqOut, 1'b0)
        t_each_bit();
        t_two_level();
        t_mask();
        t_key_hidden();
        t_line_filter();
        t_self_test();
        t_acquire();
        give_verdict();
    end

    // watchdog well beyond the roughly 4200 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        give_verdict();
    end
endmodule
